/* File: src/lce_line_eye.sv */
// Ring detect, relay drives and serial eye pattern output, with point FIFO
//
// Summary of operation
// - Each displayed point sends a horizontal word then a vertical word, 15 bits each.
// - Words go out MSB first; seven top bits zero, low eight carry the value.
// - Serial data changes on falling edges so it is stable at each rising edge.
// - The eye shift clock runs at 288 kHz.
// - Each receive bit clock rising edge also forces the eye shift clock high and restarts its divider.
// - An eye load strobe tells outside logic to load the converters.
// - Ring detect pulse trains between 15 Hz and 68 Hz count as ringing.
// - Host-programmed ring period limits replace the defaults when enabled.
// - Detected ringing shows on the ring indication pin and status bit.
// - Off-hook relay drive follows the host off-hook control bit.
// - Active off-hook drive closes the normally open relay, line connected.
// - Handset relay drive follows the host handset relay control bit.
// - Active handset drive opens the normally closed relay, handset cut off.
// - Ring indication pin is low during ring-on and high during ring-off.
// - Receive bit clock runs at data rate, rising in each bit centre.
`timescale 1ns/1ps

module lce_fifo #(
  parameter int unsigned WIDTH = lce_pkg::POINT_W,
  parameter int unsigned DEPTH = lce_pkg::EYE_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import lce_pkg::*;

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } lce_fifo_st_t;

  lce_fifo_st_t s_reg;
  lce_fifo_st_t s_next;
  logic push;
  logic pop;

  always_comb begin
    s_next = s_reg;
    push = in_valid & s_reg.rdy;
    pop = out_ready & (s_reg.cnt != '0);
    if (push) begin
      s_next.mem[s_reg.wp] = in_data;
      s_next.wp = (s_reg.wp == AW'(DEPTH - 1)) ? '0 : s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = (s_reg.rp == AW'(DEPTH - 1)) ? '0 : s_reg.rp + 1'b1;
    end
    s_next.cnt = s_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // Ready registered so the source sees it straight from a flop
    s_next.rdy = (s_next.cnt < (AW + 1)'(DEPTH));
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.rdy <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign in_ready = s_reg.rdy;
  assign out_data = s_reg.mem[s_reg.rp];
  assign out_valid = (s_reg.cnt != '0);

endmodule : lce_fifo

module lce_line_eye #(
  parameter int unsigned RING_PER_MIN_DEF = lce_pkg::RING_PER_MIN_CYC,
  parameter int unsigned RING_PER_MAX_DEF = lce_pkg::RING_PER_MAX_CYC,
  parameter int unsigned EYE_HALF = lce_pkg::EYE_HALF_CYC,
  parameter int unsigned FIFO_DEPTH = lce_pkg::EYE_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Ring detect pin and ring indication
  input wire logic ring_detect_in,
  output logic ring_indication_n,
  output logic ring_indication_status,
  // Interface memory control bits
  input wire logic off_hook_control_bit,
  input wire logic handset_relay_control_bit,
  // Ring window programmed by the host, in system clock cycles
  input wire logic ring_limit_host_en,
  input wire logic [lce_pkg::RING_CNT_W-1:0] ring_per_min_host,
  input wire logic [lce_pkg::RING_CNT_W-1:0] ring_per_max_host,
  // Relay drives
  output logic off_hook_relay_drive,
  output logic handset_relay_drive,
  // Receiver timing and constellation points
  input wire logic receive_bit_clock,
  input wire lce_pkg::lce_point_t point_data,
  input wire logic point_valid,
  output logic point_ready,
  // Eye pattern pins
  output logic eye_serial_out,
  output logic eye_shift_clock,
  output logic eye_load_strobe
);
  import lce_pkg::*;

  localparam logic [RING_CNT_W-1:0] PMIN_DEF = RING_CNT_W'(RING_PER_MIN_DEF);
  localparam logic [RING_CNT_W-1:0] PMAX_DEF = RING_CNT_W'(RING_PER_MAX_DEF);
  localparam logic [8:0] HALF_LAST = 9'(EYE_HALF - 1);
  localparam logic [EYE_CNT_W-1:0] LAST_BIT = EYE_CNT_W'(EYE_PAIR_BITS - 1);

  typedef struct packed {
    // Synchronisers: stage 1 feeds stage 2 only
    logic rd_s1;
    logic rd_s2;
    logic rd_prev;
    logic rck_s1;
    logic rck_s2;
    logic rck_prev;
    // Ring detection
    logic [RING_CNT_W-1:0] per_cnt;
    logic seen;
    logic ringing;
    logic ri_n;
    logic ri_stat;
    // Relays
    logic ohr;
    logic hsr;
    // Eye serialiser
    logic [8:0] div;
    logic eclk;
    lce_eye_st_t st;
    logic [EYE_PAIR_BITS-1:0] sh;
    logic [EYE_CNT_W-1:0] bit_cnt;
    logic sdo;
    logic strobe;
  } lce_top_st_t;

  lce_top_st_t s_reg;
  lce_top_st_t s_next;

  lce_point_t fifo_data;
  logic fifo_valid;
  logic fifo_pop;

  lce_fifo #(
    .WIDTH(POINT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_data(point_data),
    .in_valid(point_valid),
    .in_ready(point_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  always_comb begin
    logic ring_rise;
    logic rck_rise;
    logic eclk_fall;
    logic [RING_CNT_W-1:0] pmin;
    logic [RING_CNT_W-1:0] pmax;
    logic [EYE_PAIR_BITS-1:0] pair;
    ring_rise = 1'b0;
    rck_rise = 1'b0;
    eclk_fall = 1'b0;
    pmin = PMIN_DEF;
    pmax = PMAX_DEF;
    pair = '0;
    s_next = s_reg;
    fifo_pop = 1'b0;

    s_next.rd_s1 = ring_detect_in;
    s_next.rd_s2 = s_reg.rd_s1;
    s_next.rd_prev = s_reg.rd_s2;
    s_next.rck_s1 = receive_bit_clock;
    s_next.rck_s2 = s_reg.rck_s1;
    s_next.rck_prev = s_reg.rck_s2;
    ring_rise = s_reg.rd_s2 & ~s_reg.rd_prev;
    rck_rise = s_reg.rck_s2 & ~s_reg.rck_prev;

    // Host window wins over the built-in one while enabled
    if (ring_limit_host_en) begin
      pmin = ring_per_min_host;
      pmax = ring_per_max_host;
    end

    // Period between pulse edges; saturates so long gaps stay long
    if (s_reg.per_cnt != '1) begin
      s_next.per_cnt = s_reg.per_cnt + 1'b1;
    end
    if (ring_rise) begin
      // Edge cycle counts as one, so the next edge reads the whole period
      s_next.per_cnt = RING_CNT_W'(1);
      s_next.seen = 1'b1;
      // First edge only opens a measurement
      if (s_reg.seen) begin
        s_next.ringing = (s_reg.per_cnt >= pmin) && (s_reg.per_cnt <= pmax);
      end
    end else if (s_reg.per_cnt > pmax) begin
      // No pulse in the longest period: ring-off part of the cadence
      s_next.ringing = 1'b0;
    end
    s_next.ri_n = ~s_next.ringing;
    s_next.ri_stat = s_next.ringing;

    // Relay drives mirror the host bits; active means energised coil
    s_next.ohr = off_hook_control_bit;
    s_next.hsr = handset_relay_control_bit;

    // Shift clock divider
    if (s_reg.div == HALF_LAST) begin
      s_next.div = '0;
      s_next.eclk = ~s_reg.eclk;
      eclk_fall = s_reg.eclk;
    end else begin
      s_next.div = s_reg.div + 1'b1;
    end
    // Realign to the receive clock; may stretch one high phase
    if (rck_rise) begin
      s_next.div = '0;
      s_next.eclk = 1'b1;
      eclk_fall = 1'b0;
    end

    // Data moves only on falling edges, stable at the rising edge
    if (eclk_fall) begin
      s_next.strobe = 1'b0;
      unique case (s_reg.st)
        EYE_IDLE: begin
          if (fifo_valid) begin
            fifo_pop = 1'b1;
            pair = {{EYE_PAD_BITS{1'b0}}, fifo_data.horiz,
                    {EYE_PAD_BITS{1'b0}}, fifo_data.vert};
            s_next.sh = pair;
            s_next.sdo = pair[EYE_PAIR_BITS-1];
            s_next.bit_cnt = '0;
            s_next.st = EYE_SHIFT;
          end
        end
        EYE_SHIFT: begin
          if (s_reg.bit_cnt == LAST_BIT) begin
            // Whole pair out: strobe for one shift clock period
            s_next.strobe = 1'b1;
            s_next.sdo = 1'b0;
            s_next.st = EYE_IDLE;
          end else begin
            s_next.sh = {s_reg.sh[EYE_PAIR_BITS-2:0], 1'b0};
            s_next.sdo = s_reg.sh[EYE_PAIR_BITS-2];
            s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.ri_n <= RING_IND_N_RST;
      s_reg.ohr <= RELAY_RST;
      s_reg.hsr <= RELAY_RST;
      s_reg.eclk <= EYE_CLK_RST;
      s_reg.st <= EYE_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ring_indication_n = s_reg.ri_n;
  assign ring_indication_status = s_reg.ri_stat;
  assign off_hook_relay_drive = s_reg.ohr;
  assign handset_relay_drive = s_reg.hsr;
  assign eye_serial_out = s_reg.sdo;
  assign eye_shift_clock = s_reg.eclk;
  assign eye_load_strobe = s_reg.strobe;

endmodule : lce_line_eye

/* File: src/lce_pkg.sv */
// Shared constants and types for the line control and eye pattern block
package lce_pkg;

  // System clock
  localparam int unsigned SYS_CLK_HZ = 125_000_000;

  // Eye shift clock: half period rounds down so the clock is never slow
  localparam int unsigned EYE_CLK_HZ = 288_000;
  localparam int unsigned EYE_HALF_CYC = SYS_CLK_HZ / (2 * EYE_CLK_HZ);

  // Eye word layout
  localparam int unsigned EYE_WORD_BITS = 15;
  localparam int unsigned EYE_SIG_BITS = 8;
  localparam int unsigned EYE_PAD_BITS = EYE_WORD_BITS - EYE_SIG_BITS;
  localparam int unsigned EYE_PAIR_BITS = 2 * EYE_WORD_BITS;
  localparam int unsigned EYE_CNT_W = 5;

  // Ring frequency window, printed in Hz
  localparam int unsigned RING_MIN_HZ = 15;
  localparam int unsigned RING_MAX_HZ = 68;
  // Longest accepted period rounds down, shortest rounds up
  localparam int unsigned RING_PER_MAX_CYC = SYS_CLK_HZ / RING_MIN_HZ;
  localparam int unsigned RING_PER_MIN_CYC = (SYS_CLK_HZ + RING_MAX_HZ - 1) / RING_MAX_HZ;
  localparam int unsigned RING_CNT_W = 24;

  // Buffering
  localparam int unsigned EYE_FIFO_DEPTH = 4;

  // Reset values
  localparam logic RING_IND_N_RST = 1'b1;
  localparam logic RELAY_RST = 1'b0;
  localparam logic EYE_CLK_RST = 1'b0;

  // One constellation point as shown on the scope
  typedef struct packed {
    logic [EYE_SIG_BITS-1:0] horiz;
    logic [EYE_SIG_BITS-1:0] vert;
  } lce_point_t;

  localparam int unsigned POINT_W = $bits(lce_point_t);

  typedef enum logic [0:0] {
    EYE_IDLE,
    EYE_SHIFT
  } lce_eye_st_t;

endpackage : lce_pkg

/* File: verification/lce_line_eye_assertions.sv */
// Port-level checks for the line control and eye pattern block
`timescale 1ns/1ps
module lce_line_eye_assertions #(
  parameter int unsigned EYE_HALF = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Relay and ring pins
  input wire logic off_hook_control_bit,
  input wire logic handset_relay_control_bit,
  input wire logic off_hook_relay_drive,
  input wire logic handset_relay_drive,
  input wire logic ring_indication_n,
  input wire logic ring_indication_status,
  // Eye pins
  input wire logic receive_bit_clock,
  input wire logic point_ready,
  input wire logic eye_serial_out,
  input wire logic eye_shift_clock,
  input wire logic eye_load_strobe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Phase length; first phase after reset is not judged
  int run_reg;
  logic armed_reg;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      run_reg <= 0;
      armed_reg <= 1'b0;
    end else if ($changed(eye_shift_clock)) begin
      run_reg <= 1;
      armed_reg <= 1'b1;
    end else begin
      run_reg <= run_reg + 1;
    end
  end
  chk_relay_offhook: assert property (
    !$past(srst) |-> off_hook_relay_drive == $past(off_hook_control_bit)) else $error("off-hook drive wrong");
  chk_relay_handset: assert property (
    !$past(srst) |-> handset_relay_drive == $past(handset_relay_control_bit)) else $error("handset drive wrong");
  chk_ring_pins: assert property (
    ring_indication_n != ring_indication_status) else $error("ring pin and status disagree");
  chk_data_on_fall: assert property (
    $changed(eye_serial_out) |-> $fell(eye_shift_clock)) else $error("eye data moved off a falling edge");
  chk_strobe_on_fall: assert property (
    $changed(eye_load_strobe) |-> $fell(eye_shift_clock)) else $error("strobe moved off a falling edge");
  chk_strobe_idle: assert property (
    eye_load_strobe |-> !eye_serial_out) else $error("data high during strobe");
  chk_high_min: assert property (
    $fell(eye_shift_clock) && armed_reg |-> run_reg >= EYE_HALF) else $error("eye clock high too short");
  chk_low_max: assert property (
    $rose(eye_shift_clock) && armed_reg |-> run_reg <= EYE_HALF) else $error("eye clock low too long");
  chk_realign_rise: assert property (
    $rose(receive_bit_clock) |-> ##[1:5] eye_shift_clock) else $error("eye clock not high after bit clock");
  cover property ($rose(eye_load_strobe));
  cover property ($fell(ring_indication_n));
  cover property ($fell(point_ready));
endmodule : lce_line_eye_assertions

bind lce_line_eye lce_line_eye_assertions #(.EYE_HALF(EYE_HALF)) lce_line_eye_assertions_inst (
  .clk_sys(clk_sys), .srst(srst), .off_hook_control_bit(off_hook_control_bit),
  .handset_relay_control_bit(handset_relay_control_bit), .off_hook_relay_drive(off_hook_relay_drive),
  .handset_relay_drive(handset_relay_drive), .ring_indication_n(ring_indication_n),
  .ring_indication_status(ring_indication_status), .receive_bit_clock(receive_bit_clock),
  .point_ready(point_ready), .eye_serial_out(eye_serial_out), .eye_shift_clock(eye_shift_clock),
  .eye_load_strobe(eye_load_strobe));

/* File: verification/lce_s2p_model.sv */
// Serial-to-parallel converter model feeding the two D/A words
`timescale 1ns/1ps
module lce_s2p_model (
  // Eye pins
  input wire logic eye_serial_out,
  input wire logic eye_shift_clock,
  input wire logic eye_load_strobe,
  // Converter words
  output logic [14:0] dac_x,
  output logic [14:0] dac_y,
  output int loads
);
  logic [29:0] sh_reg;
  initial loads = 0;
  always @(posedge eye_shift_clock) sh_reg <= {sh_reg[28:0], eye_serial_out};
  always @(posedge eye_load_strobe) begin
    dac_x <= sh_reg[29:15];
    dac_y <= sh_reg[14:0];
    loads <= loads + 1;
  end
endmodule : lce_s2p_model

/* File: verification/tb.sv */
// Self-checking bench for the line control and eye pattern block
`timescale 1ns/1ps
module tb;
  import lce_pkg::*;
  localparam int MIN_D = 20;
  localparam int MAX_D = 100;
  logic clk_sys = '0, srst = '1, ring_detect_in = '0, off_hook_control_bit = '0, handset_relay_control_bit = '0;
  logic ring_limit_host_en = '0, receive_bit_clock = '0, point_valid = '0, rbc_en = '0, saw_full = '0;
  logic [RING_CNT_W-1:0] ring_per_min_host = '0, ring_per_max_host = '0;
  lce_point_t point_data = '0;
  lce_point_t p;
  lce_point_t exp_q[$];
  logic ring_indication_n, ring_indication_status, off_hook_relay_drive, handset_relay_drive, point_ready;
  logic eye_serial_out, eye_shift_clock, eye_load_strobe;
  logic [14:0] dac_x, dac_y;
  logic [1:0] rb;
  int loads, fails = 0, comparisons = 0, cyc = 0;
  int pers[5] = '{20, 100, 19, 101, 50};

  lce_line_eye #(.RING_PER_MIN_DEF(MIN_D), .RING_PER_MAX_DEF(MAX_D), .EYE_HALF(4)) lce_line_eye_inst (.*);
  lce_s2p_model lce_s2p_model_inst (.*);

  initial forever #4 clk_sys = ~clk_sys;
  // Bit clock at 64 ns, toggling on falling system edges, never on a rising one
  initial forever #32 receive_bit_clock = rbc_en & ~receive_bit_clock;

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic ring_train(input int per, input int lo, input int hi);
    repeat (5) begin
      ring_detect_in <= '1;
      repeat (5) @(posedge clk_sys);
      ring_detect_in <= '0;
      repeat (per - 5) @(posedge clk_sys);
    end
    ring_detect_in <= '1;
    repeat (8) @(posedge clk_sys);
    chk(ring_indication_status, per >= lo && per <= hi);
    chk(ring_indication_n, !(per >= lo && per <= hi));
    ring_detect_in <= '0;
    repeat (hi + 20) @(posedge clk_sys);
    chk(ring_indication_status, 0);
  endtask : ring_train

  always @(posedge clk_sys) begin
    cyc++;
    if (!srst && point_valid && point_ready) exp_q.push_back(point_data);
    if (!srst && !point_ready) saw_full = '1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  // Each converter load must match the next accepted point
  always begin
    @(loads);
    #1;
    p = exp_q.pop_front();
    chk(dac_x, {7'h0, p.horiz});
    chk(dac_y, {7'h0, p.vert});
  end

  initial begin
    void'($urandom(14233));
    repeat (20) @(posedge clk_sys);
    srst <= '0;
    @(posedge clk_sys);
    chk({ring_indication_n, ring_indication_status, point_ready}, 3'h5);
    repeat (16) begin
      rb = 2'($urandom);
      {off_hook_control_bit, handset_relay_control_bit} <= rb;
      repeat (2) @(posedge clk_sys);
      chk(off_hook_relay_drive, rb[1]);
      chk(handset_relay_drive, rb[0]);
    end
    rbc_en = '1;
    for (int i = 0; i < 6; i++) begin
      point_data <= 16'($urandom);
      point_valid <= '1;
      do @(posedge clk_sys); while (!point_ready);
    end
    point_valid <= '0;
    chk(saw_full, 1);
    while (loads < 6) @(posedge clk_sys);
    repeat (40) @(posedge clk_sys);
    chk(16'(loads), 6);
    rbc_en = '0;
    foreach (pers[i]) ring_train(pers[i], MIN_D, MAX_D);
    ring_per_min_host <= 24'h0000c8;
    ring_per_max_host <= 24'h00012c;
    ring_limit_host_en <= '1;
    ring_train(250, 200, 300);
    ring_train(150, 200, 300);
    tally_and_finish();
  end
endmodule : tb
